// file: csr_pkg.sv
// Constants for the core status and interrupt control register block
package csr_pkg;
  localparam logic [3:0] CSR_MODULE      = 4'h8;
  localparam logic [3:0] CSR_IDX_ASEL    = 4'h0;
  localparam logic [3:0] CSR_IDX_STEP    = 4'h1;
  localparam logic [3:0] CSR_IDX_FLAGS   = 4'h4;
  localparam logic [3:0] CSR_IDX_ICTL    = 4'h5;
  localparam logic [3:0] CSR_IDX_MASK    = 4'h6;
  localparam logic [7:0] CSR_ASEL_RST    = 8'h00;
  localparam logic [7:0] CSR_STEP_RST    = 8'h00;
  localparam logic [7:0] CSR_FLAGS_RST   = 8'h80;
  localparam logic [7:0] CSR_ICTL_RST    = 8'h00;
  localparam logic [7:0] CSR_MASK_RST    = 8'h00;
  localparam int         CSR_STEP_CLR    = 7;
  localparam int         CSR_STEP_DIR    = 6;
  localparam int         CSR_FLAG_Z      = 7;
  localparam int         CSR_FLAG_S      = 6;
  localparam int         CSR_FLAG_U1     = 4;
  localparam int         CSR_FLAG_U0     = 3;
  localparam int         CSR_FLAG_OV     = 2;
  localparam int         CSR_FLAG_C      = 1;
  localparam int         CSR_FLAG_E      = 0;
  localparam int         CSR_IC_GE       = 0;
  localparam int         CSR_IC_INS      = 1;
  localparam int         CSR_MASK_SYS    = 7;
  localparam logic [7:0] CSR_FLAGS_WMASK = 8'h1B;
  localparam logic [7:0] CSR_MASK_WMASK  = 8'hBF;
endpackage

// file: csr_regs.sv
// Core status, accumulator select and interrupt control registers
`timescale 1ns/1ps
// Behaviour
// R1: Four-bit pointer picks one of sixteen accumulators
// R2: Pointer auto-steps after each ALU operation unless modulus code is zero
// R3: Auto-step beats a move into pointer
// R4: Modulus code selects wrap width, 5-7 act 16
// R5: Direction bit: zero increments, one decrements
// R6: Clear bit zeroes pointer, self-clears, reads zero
// R7: Compare sets equal flag on match
// R8: Add/subtract carry or borrow sets carry flag
// R9: Overflow is XOR of bit 14/15 carries
// R10: Sign flag mirrors selected accumulator bit 15
// R11: Zero flag set when selected accumulator zero
// R12: Flags: Z,S,OV read-only, others writable, reset 80h
// R13: Global enable low blocks all interrupts
// R14: Acknowledge sets in-service, which blocks further
// R15: In-service cleared by software or return
// R16: Mask bits gate modules 0-5 and system
// R17: Pointer, control, interrupt registers reset to 00h
// R18: Reserved bits read as zero
// R19: Registers addressed by module 8h and index
module csr_regs
  import csr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_module,
  input  wire logic [3:0]  reg_index,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        alu_op,
  input  wire logic        cmp_op,
  input  wire logic        cmp_equal,
  input  wire logic        addsub_op,
  input  wire logic        addsub_carry,
  input  wire logic        arith_op,
  input  wire logic        carry14,
  input  wire logic        carry15,
  input  wire logic [15:0] acc_value,
  input  wire logic [5:0]  module_irq,
  input  wire logic        system_irq,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  output logic      [3:0]  acc_sel,
  output logic             irq_request
);

  typedef struct packed {
    logic [3:0] asel;
    logic [2:0] modulus;
    logic       dir;
    logic       eq;
    logic       cy;
    logic       ov;
    logic       u0;
    logic       u1;
    logic       ge;
    logic       irq_in_service;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic       irq;
  } csr_state_t;

  csr_state_t q, d;
  logic       sel_hit;
  logic [7:0] flags_now;
  logic [3:0] span;
  logic [3:0] stepped;
  logic       zero_now;

  // Zero and sign are live views of the selected accumulator, not stored
  assign zero_now = (acc_value == 16'h0000); // R11

  always_comb
  begin
    flags_now                = 8'h00; // R18
    flags_now[CSR_FLAG_Z]    = zero_now; // R11
    flags_now[CSR_FLAG_S]    = acc_value[15]; // R10
    flags_now[CSR_FLAG_U1]   = q.u1;
    flags_now[CSR_FLAG_U0]   = q.u0;
    flags_now[CSR_FLAG_OV]   = q.ov;
    flags_now[CSR_FLAG_C]    = q.cy;
    flags_now[CSR_FLAG_E]    = q.eq;
  end

  // Wrap mask per modulus code
  always_comb
  begin
    unique case (q.modulus) // R4
      3'h1:    span = 4'h1;
      3'h2:    span = 4'h3;
      3'h3:    span = 4'h7;
      default: span = 4'hF;
    endcase
    // Bits above the span stay fixed; only the low field wraps
    if (q.dir) // R5
      stepped = (q.asel & ~span) | ((q.asel - 4'h1) & span);
    else
      stepped = (q.asel & ~span) | ((q.asel + 4'h1) & span);
  end

  assign sel_hit = (reg_module == CSR_MODULE); // R19

  always_comb
  begin
    d     = q;
    d.irq = 1'b0;
    if (reg_wr && sel_hit)
    begin
      unique case (reg_index)
        CSR_IDX_ASEL:  d.asel = reg_wdata[3:0]; // R1
        CSR_IDX_STEP:
        begin
          d.modulus = reg_wdata[2:0];
          d.dir     = reg_wdata[CSR_STEP_DIR];
        end
        CSR_IDX_FLAGS:
        begin
          d.eq = reg_wdata[CSR_FLAG_E]; // R12
          d.cy = reg_wdata[CSR_FLAG_C];
          d.u0 = reg_wdata[CSR_FLAG_U0];
          d.u1 = reg_wdata[CSR_FLAG_U1];
        end
        CSR_IDX_ICTL:
        begin
          d.ge  = reg_wdata[CSR_IC_GE];
          d.irq_in_service = reg_wdata[CSR_IC_INS]; // R15
        end
        CSR_IDX_MASK:  d.mask = reg_wdata & CSR_MASK_WMASK;
        default:       d.asel = d.asel;
      endcase
    end
    // Hardware flag updates win over a software write in the same cycle
    if (cmp_op)
      d.eq = cmp_equal; // R7
    if (addsub_op)
      d.cy = addsub_carry; // R8
    if (arith_op)
      d.ov = carry14 ^ carry15; // R9
    // Step wins over a move into the pointer
    if (alu_op && (q.modulus != 3'h0)) // R2 R3
      d.asel = stepped;
    // Clear overrides stepping; the bit is never stored
    if (reg_wr && sel_hit && (reg_index == CSR_IDX_STEP) && reg_wdata[CSR_STEP_CLR])
      d.asel = 4'h0; // R6
    // Return clears, acknowledge sets; acknowledge wins if both
    if (irq_return)
      d.irq_in_service = 1'b0; // R15
    if (irq_ack)
      d.irq_in_service = 1'b1; // R14
    d.irq = q.ge && !q.irq_in_service && // R13 R14
            (|(module_irq & q.mask[5:0]) || (system_irq && q.mask[CSR_MASK_SYS])); // R16
    d.rdata = 8'h00;
    if (reg_rd && sel_hit)
    begin
      unique case (reg_index)
        CSR_IDX_ASEL:  d.rdata = {4'h0, q.asel}; // R18
        CSR_IDX_STEP:  d.rdata = {1'b0, q.dir, 3'b000, q.modulus}; // R6 R18
        CSR_IDX_FLAGS: d.rdata = flags_now;
        CSR_IDX_ICTL:  d.rdata = {6'h00, q.irq_in_service, q.ge};
        CSR_IDX_MASK:  d.rdata = q.mask;
        default:       d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q         <= '0; // R17
      q.asel    <= CSR_ASEL_RST[3:0];
      q.modulus <= CSR_STEP_RST[2:0];
      q.mask    <= CSR_MASK_RST;
      q.ge      <= CSR_ICTL_RST[0];
      q.eq      <= CSR_FLAGS_RST[0];
    end
    else
      q <= d;
  end

  assign acc_sel     = q.asel;
  assign reg_rdata   = q.rdata;
  assign irq_request = q.irq;

  // Only a clear may override the step, so a pointer write beside the op still counts
  a_step_inc: assert property (@(posedge clk) disable iff (!rstn) // R2
    alu_op && q.modulus == 3'h4 && !q.dir
    && !(reg_wr && sel_hit && reg_index == CSR_IDX_STEP && reg_wdata[CSR_STEP_CLR])
    |=> q.asel == $past(q.asel) + 4'h1)
    else $error("pointer did not increment");
  a_step_dec2: assert property (@(posedge clk) disable iff (!rstn) // R4
    alu_op && q.modulus == 3'h1 && q.dir
    && !(reg_wr && sel_hit && reg_index == CSR_IDX_STEP && reg_wdata[CSR_STEP_CLR])
    |=> q.asel == {$past(q.asel[3:1]), ~$past(q.asel[0])})
    else $error("modulo 2 decrement wrong");
  a_no_step: assert property (@(posedge clk) disable iff (!rstn) // R2
    alu_op && q.modulus == 3'h0 && !reg_wr |=> q.asel == $past(q.asel))
    else $error("pointer moved without stepping");
  a_clear_wins: assert property (@(posedge clk) disable iff (!rstn) // R6
    reg_wr && sel_hit && reg_index == CSR_IDX_STEP && reg_wdata[CSR_STEP_CLR]
    |=> q.asel == 4'h0)
    else $error("pointer clear lost");
  a_ovf_xor: assert property (@(posedge clk) disable iff (!rstn) // R9
    arith_op |=> q.ov == ($past(carry14) ^ $past(carry15)))
    else $error("overflow flag wrong");
  a_zero_read: assert property (@(posedge clk) disable iff (!rstn) // R11
    reg_rd && sel_hit && reg_index == CSR_IDX_FLAGS
    |=> reg_rdata[7] == $past(zero_now) && reg_rdata[5] == 1'b0)
    else $error("zero flag readback wrong");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rstn) // R13
    !q.ge || q.irq_in_service |=> !irq_request)
    else $error("interrupt delivered while blocked");
  a_ins_set: assert property (@(posedge clk) disable iff (!rstn) // R14
    irq_ack |=> q.irq_in_service ##1 !irq_request)
    else $error("in-service not set on acknowledge");
  a_ins_ret: assert property (@(posedge clk) disable iff (!rstn) // R15
    irq_return && !irq_ack |=> !q.irq_in_service)
    else $error("return did not clear in-service");
  a_mask_gate: assert property (@(posedge clk) disable iff (!rstn) // R16
    q.mask == 8'h00 |=> !irq_request)
    else $error("masked request delivered");

endmodule // csr_regs

// file: tb.sv
// Self-checking testbench for the core status register block
`timescale 1ns/1ps
module tb;
  import csr_pkg::*;
  logic        clk, rstn, reg_wr, reg_rd, alu_op, cmp_op, cmp_equal, addsub_op;
  logic        addsub_carry, arith_op, carry14, carry15, system_irq, irq_ack, irq_return;
  logic        irq_request;
  logic [3:0]  reg_module, reg_index, acc_sel;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] acc_value;
  logic [5:0]  module_irq;
  int          n_fail, n_compared;
  csr_regs dut (.clk(clk), .rstn(rstn), .reg_module(reg_module), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alu_op(alu_op), .cmp_op(cmp_op), .cmp_equal(cmp_equal), .addsub_op(addsub_op),
    .addsub_carry(addsub_carry), .arith_op(arith_op), .carry14(carry14), .carry15(carry15),
    .acc_value(acc_value), .module_irq(module_irq), .system_irq(system_irq),
    .irq_ack(irq_ack), .irq_return(irq_return), .acc_sel(acc_sel), .irq_request(irq_request));
  always #12.5 clk = ~clk;
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Optional alu pulse rides on the write edge to test hardware priority
  task wr(input logic [3:0] m, input logic [3:0] i, input logic [7:0] v, input logic a);
    @(posedge clk);
    reg_module <= m;
    reg_index <= i;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    alu_op <= a;
    @(posedge clk);
    reg_wr <= 1'b0;
    alu_op <= 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [3:0] m, input logic [3:0] i, input logic [7:0] e);
    @(posedge clk);
    reg_module <= m;
    reg_index <= i;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    cyc(0);
    chk(reg_rdata, e);
  endtask
  function automatic logic [3:0] nxt(input logic [3:0] p, input int m, input int dn);
    logic [3:0] k;
    k = (m == 0) ? 4'h0 : (m == 1) ? 4'h1 : (m == 2) ? 4'h3 : (m == 3) ? 4'h7 : 4'hF;
    return (p & ~k) | ((dn != 0 ? p - 4'h1 : p + 4'h1) & k);
  endfunction
  task t_reset();
    rd(4'h8, 4'h0, 8'h00);
    rd(4'h8, 4'h1, 8'h00);
    rd(4'h8, 4'h4, CSR_FLAGS_RST);
    rd(4'h8, 4'h5, 8'h00);
    rd(4'h8, 4'h6, 8'h00);
    wr(4'h9, 4'h0, 8'h0F, 1'b0);
    rd(4'h8, 4'h0, 8'h00);
    wr(4'h8, 4'h0, 8'hFF, 1'b0);
    rd(4'h8, 4'h0, 8'h0F);
    rd(4'h8, 4'h2, 8'h00);
    chk(acc_sel, 8'h0F);
    $display("reset and decode test done");
  endtask
  task t_step();
    for (int m = 0; m < 8; m++)
      for (int dn = 0; dn < 2; dn++)
      begin
        wr(4'h8, 4'h1, {1'b1, dn[0], 3'b111, m[2:0]}, 1'b0);
        wr(4'h8, 4'h0, 8'h07, 1'b0);
        rd(4'h8, 4'h1, {2'b00, 3'b000, m[2:0]} | (dn[0] << 6));
        wr(4'h8, 4'h7, 8'h00, 1'b1);
        chk(acc_sel, nxt(4'h7, m, dn));
      end
    wr(4'h8, 4'h1, 8'h04, 1'b0);
    wr(4'h8, 4'h0, 8'h02, 1'b0);
    wr(4'h8, 4'h0, 8'h09, 1'b1);
    chk(acc_sel, 8'h03);
    wr(4'h8, 4'h1, 8'h84, 1'b1);
    chk(acc_sel, 8'h00);
    $display("pointer step test done");
  endtask
  task fl(input logic e, input logic c, input logic c14, input logic c15);
    @(posedge clk);
    {cmp_op, addsub_op, arith_op} <= 3'b111;
    {cmp_equal, addsub_carry, carry14, carry15} <= {e, c, c14, c15};
    @(posedge clk);
    {cmp_op, addsub_op, arith_op} <= 3'b000;
  endtask
  task t_flags();
    @(posedge clk);
    acc_value <= 16'h8000;
    wr(4'h8, 4'h4, 8'hFF, 1'b0);
    rd(4'h8, 4'h4, 8'h5B);
    fl(1'b0, 1'b0, 1'b1, 1'b0);
    rd(4'h8, 4'h4, 8'h5C);
    @(posedge clk);
    acc_value <= 16'h0000;
    fl(1'b1, 1'b1, 1'b1, 1'b1);
    rd(4'h8, 4'h4, 8'h9B);
    $display("flag test done");
  endtask
  task pulse_irq(input logic ret);
    @(posedge clk);
    {irq_ack, irq_return} <= {~ret, ret};
    @(posedge clk);
    {irq_ack, irq_return} <= 2'b00;
    cyc(2);
  endtask
  task t_irq();
    wr(4'h8, 4'h6, 8'hFF, 1'b0);
    rd(4'h8, 4'h6, CSR_MASK_WMASK);
    cyc(2);
    chk(irq_request, 8'h00);
    wr(4'h8, 4'h5, 8'hFD, 1'b0);
    rd(4'h8, 4'h5, 8'h01);
    chk(irq_request, 8'h01);
    pulse_irq(1'b0);
    rd(4'h8, 4'h5, 8'h03);
    chk(irq_request, 8'h00);
    pulse_irq(1'b1);
    chk(irq_request, 8'h01);
    pulse_irq(1'b0);
    wr(4'h8, 4'h5, 8'h01, 1'b0);
    rd(4'h8, 4'h5, 8'h01);
    wr(4'h8, 4'h6, 8'h80, 1'b0);
    cyc(2);
    chk(irq_request, 8'h00);
    system_irq <= 1'b1;
    cyc(3);
    chk(irq_request, 8'h01);
    $display("interrupt test done");
  endtask
  task print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {clk, rstn, reg_wr, reg_rd, alu_op, cmp_op, cmp_equal, addsub_op} = '0;
    {addsub_carry, arith_op, carry14, carry15, system_irq, irq_ack, irq_return} = '0;
    {reg_module, reg_index, reg_wdata, acc_value} = '0;
    module_irq = 6'h02;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_step();
    t_flags();
    t_irq();
    print_verdict();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // tb
